/* logic/tcs_cfg.svh */
// constants of the transmit sideband decoder
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH
// ****************************************
// sideband field positions
// ****************************************
`define TCS_USER_W        100
`define TCS_DATA_W        512
`define TCS_SOP_LO        0
`define TCS_SOP_HI        3
`define TCS_SLOT0_LO      4
`define TCS_SLOT_W        2
`define TCS_EOP_LO        12
`define TCS_EOP_HI        15
`define TCS_ABORT_LO      16
`define TCS_ABORT_HI      19
`define TCS_EDW0_LO       20
`define TCS_EDW_W         4
`define TCS_PAR_LO        36
`define TCS_PAR_HI        99
`define TCS_LANES         4
`define TCS_SLOT_BYTES    16
// ****************************************
// credit and register constants
// ****************************************
`define TCS_CREDITS       4'h8
`define TCS_CRED_W        4
`define TCS_ADDR_W        4
`define TCS_REG_CTRL      4'h0
`define TCS_REG_STAT      4'h1
`define TCS_REG_MASK      4'h2
`define TCS_REG_CRED      4'h3
`define TCS_REG_COUNT     4'h4
`define TCS_EV_W          4
`define TCS_EV_ABORT      0
`define TCS_EV_PARITY     1
`define TCS_EV_CODE       2
`define TCS_EV_SEQ        3
`define TCS_CTRL_RESET    2'h0
`endif

/* logic/tcs_pkg.sv */
// types of the transmit sideband decoder
package tcs_pkg;
    // link state for credit release
    typedef enum logic [1:0] {
        TCS_IDLE,
        TCS_GRANT,
        TCS_RUN
    } tcs_link_t;
endpackage : tcs_pkg

/* logic/tcs_field_check.sv */
// combinational check of one sideband word: code legality and parity
`timescale 1ns/1ps
`include "tcs_cfg.svh"
module tcs_field_check
    import tcs_pkg::*;
#(
    parameter int DATA_W = `TCS_DATA_W,
    parameter int USER_W = `TCS_USER_W
) (
    input  wire logic [DATA_W-1:0] i_data,     // beat data
    input  wire logic [USER_W-1:0] i_user,     // beat sideband
    output logic                   o_code_bad, // reserved encoding seen
    output logic                   o_par_bad   // byte parity mismatch
);
    // ****************************************
    // helpers
    // ****************************************
    // thermometer legality, used for both flag fields
    function automatic logic therm_ok(input logic [3:0] v);
        therm_ok = (v == 4'h0) || (v == 4'h1) || (v == 4'h3) || (v == 4'h7) || (v == 4'hf);
    endfunction : therm_ok

    wire logic [3:0] sop_w = i_user[`TCS_SOP_HI:`TCS_SOP_LO];     // start count flags [RL3]
    wire logic [3:0] eop_w = i_user[`TCS_EOP_HI:`TCS_EOP_LO];     // end count flags [RL4]
    logic [`TCS_LANES-1:0] slot_bad;                              // per start slot order fault
    logic [DATA_W/8-1:0]   byte_bad;                              // per byte parity fault

    // ****************************************
    // start slot ordering
    // ****************************************
    // later start slot must lie strictly after the previous one
    genvar g;
    generate
        for (g = 1; g < `TCS_LANES; g++) begin : g_slot
            wire logic [1:0] cur_w = i_user[`TCS_SLOT0_LO+g*`TCS_SLOT_W +: `TCS_SLOT_W]; // [RL2]
            wire logic [1:0] prv_w = i_user[`TCS_SLOT0_LO+(g-1)*`TCS_SLOT_W +: `TCS_SLOT_W];
            assign slot_bad[g] = sop_w[g] && (cur_w <= prv_w);      // [RL2]
        end
        for (g = 0; g < DATA_W/8; g++) begin : g_par
            // odd parity: xor of byte and its bit must be one
            assign byte_bad[g] = ~(^i_data[g*8 +: 8] ^ i_user[`TCS_PAR_LO+g]); // [RL13]
        end
    endgenerate
    assign slot_bad[0] = 1'b0;                                    // first slot takes any code [RL1]

    assign o_code_bad = !therm_ok(sop_w) || !therm_ok(eop_w) || (|slot_bad); // [RL15]
    assign o_par_bad  = |byte_bad;
endmodule : tcs_field_check

/* logic/tcs_tx_sideband.sv */
// transmit stream sideband decoder with credits, abort and parity handling
`timescale 1ns/1ps
`include "tcs_cfg.svh"
// Function
// (RL1) first start slot bits 5:4, 16-byte steps
// (RL2) later start slots 7:6,9:8,11:10, ascending
// (RL3) start flags 3:0 thermometer count
// (RL4) end flags 15:12 thermometer count
// (RL5) sender ends packet only on last beat
// (RL6) end dword 23:20 used when end bit0
// (RL7) end dword 27:24 used when end bit1
// (RL8) end dwords 31:28,35:32 with bits 2,3
// (RL9) sender may flag abort in 19:16
// (RL10) aborted packet is nullified on link
// (RL11) abort any beat, end now or later
// (RL12) abort only with valid, held to end
// (RL13) odd byte parity 99:36, error nullifies
// (RL14) eight credits granted after link active
// (RL15) reserved encodings treated as protocol error
module tcs_tx_sideband
    import tcs_pkg::*;
#(
    parameter int DATA_W  = `TCS_DATA_W,
    parameter int USER_W  = `TCS_USER_W
) (
    input  wire logic                   i_clk,          // 100 MHz user clock
    input  wire logic                   i_reset_n,      // synchronous reset, low active
    input  wire logic [DATA_W-1:0]      i_tx_data,      // beat data
    input  wire logic [USER_W-1:0]      i_tx_user,      // beat sideband word
    input  wire logic                   i_tx_valid,     // beat valid
    input  wire logic                   i_active_req,   // sender wants link active
    input  wire logic                   i_credit_rtn,   // credit return, unused; consumed beats return credits
    output logic                        o_active_ack,   // core ready for packets
    output logic                        o_credit_gnt,   // one credit released
    output logic [3:0]                  o_end_valid,    // packets ending this beat
    output logic [3:0]                  o_end_nullify,  // ending packet must be nullified
    output logic [15:0]                 o_end_dword,    // last dword index per ending lane
    output logic [7:0]                  o_start_byte0,  // byte of first start
    output logic                        o_uncorr_err,   // uncorrectable internal error pulse
    input  wire logic [`TCS_ADDR_W-1:0] i_reg_addr,     // register address
    input  wire logic [31:0]            i_reg_wdata,    // register write data
    input  wire logic                   i_reg_wr,       // write strobe
    input  wire logic                   i_reg_rd,       // read strobe
    output logic [31:0]                 o_reg_rdata,    // read data, one cycle later
    output logic                        o_irq           // level interrupt
);
    // ****************************************
    // decode of the sideband word
    // ****************************************
    wire logic [3:0] start_count_flags = i_tx_user[`TCS_SOP_HI:`TCS_SOP_LO];       // [RL3]
    wire logic [3:0] end_count_flags   = i_tx_user[`TCS_EOP_HI:`TCS_EOP_LO];       // [RL4]
    wire logic [3:0] abort_flags       = i_tx_user[`TCS_ABORT_HI:`TCS_ABORT_LO];
    wire logic [1:0] first_start_slot  = i_tx_user[`TCS_SLOT0_LO +: `TCS_SLOT_W];  // [RL1]
    wire logic [15:0] end_dwords       = i_tx_user[`TCS_EDW0_LO +: 16];            // [RL6] [RL7] [RL8]
    wire logic beat_w  = i_tx_valid && o_active_ack;                               // accepted beat
    wire logic code_bad;                                                           // reserved code
    wire logic par_bad;                                                            // parity fault

    tcs_field_check #(
        .DATA_W (DATA_W),
        .USER_W (USER_W)
    ) u_check (
        .i_data     (i_tx_data),
        .i_user     (i_tx_user),
        .o_code_bad (code_bad),
        .o_par_bad  (par_bad)
    );

    // ****************************************
    // register state
    // ****************************************
    logic                 par_en_q;         // parity checking enable
    logic                 drop_code_q;      // nullify on reserved code too
    logic [`TCS_EV_W-1:0] stat_q;           // sticky event bits
    logic [`TCS_EV_W-1:0] mask_q;           // interrupt mask, 1 enables
    logic [31:0]          rdata_q;          // read data register
    logic [15:0]          pkt_count_q;      // packets ended
    logic                 in_pkt_q;         // a packet is open across beats
    logic                 taint_q;          // open packet already doomed
    logic [`TCS_CRED_W-1:0] credit_q;       // credits held by sender
    logic [`TCS_CRED_W-1:0] pend_q;         // credits still to release
    tcs_link_t            link_q;           // link state

    // ****************************************
    // packet continuity and nullify
    // ****************************************
    // count of starts and ends this beat
    function automatic logic [2:0] therm_cnt(input logic [3:0] v);
        therm_cnt = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
    endfunction : therm_cnt

    wire logic [2:0] n_sop = therm_cnt(start_count_flags);
    wire logic [2:0] n_eop = therm_cnt(end_count_flags);
    // a beat with no end leaves the last started packet open; an end with
    // more ends than starts closes the carried-over one as lane 0
    wire logic carry_in  = in_pkt_q;
    wire logic open_out  = (n_sop + 3'(carry_in)) > n_eop;                          // [RL5]
    wire logic seq_bad   = beat_w && ((n_eop > n_sop + 3'(carry_in)) ||
                                      (carry_in && n_sop != 3'h0 && n_eop == 3'h0));
    wire logic beat_err  = (par_en_q && par_bad) || (drop_code_q && code_bad);     // [RL13]
    // any abort bit or error dooms the packet left open by this beat; abort stays
    // high to the end, so a per-beat view is enough here
    wire logic doom_w    = (|abort_flags) || beat_err;                             // [RL10] [RL12]
    wire logic [3:0] null_w;
    genvar l;
    generate
        for (l = 0; l < `TCS_LANES; l++) begin : g_null
            wire logic carried = (l == 0) && carry_in;
            assign null_w[l] = end_count_flags[l] && (abort_flags[l] || beat_err ||
                               (carried && taint_q));                              // [RL10] [RL11]
        end
    endgenerate

    // ****************************************
    // events
    // ****************************************
    wire logic [`TCS_EV_W-1:0] ev_w;
    assign ev_w[`TCS_EV_ABORT]  = beat_w && (|abort_flags);                       // [RL9]
    assign ev_w[`TCS_EV_PARITY] = beat_w && par_en_q && par_bad;                  // [RL13]
    assign ev_w[`TCS_EV_CODE]   = beat_w && code_bad;                             // [RL15]
    assign ev_w[`TCS_EV_SEQ]    = seq_bad;                                        // [RL5]

    // ****************************************
    // register decode
    // ****************************************
    wire logic wr_ctrl = i_reg_wr && (i_reg_addr == `TCS_REG_CTRL);
    wire logic wr_stat = i_reg_wr && (i_reg_addr == `TCS_REG_STAT);
    wire logic wr_mask = i_reg_wr && (i_reg_addr == `TCS_REG_MASK);
    wire logic [31:0] rd_mux =
        (i_reg_addr == `TCS_REG_CTRL)  ? {30'h0, drop_code_q, par_en_q} :
        (i_reg_addr == `TCS_REG_STAT)  ? {28'h0, stat_q} :
        (i_reg_addr == `TCS_REG_MASK)  ? {28'h0, mask_q} :
        (i_reg_addr == `TCS_REG_CRED)  ? {28'h0, credit_q} :
        (i_reg_addr == `TCS_REG_COUNT) ? {16'h0, pkt_count_q} : 32'h0;
    // set wins over the write-one clear
    wire logic [`TCS_EV_W-1:0] stat_d = ev_w | (stat_q & ~(wr_stat ? i_reg_wdata[`TCS_EV_W-1:0] : 4'h0));

    // ****************************************
    // credits
    // ****************************************
    // sender spends one credit per accepted beat; held count is informative
    wire logic grant_w = (link_q != TCS_IDLE) && (pend_q != 4'h0);                 // [RL14]
    wire logic [`TCS_CRED_W-1:0] credit_d = credit_q + (grant_w ? 4'h1 : 4'h0) - (beat_w ? 4'h1 : 4'h0);
    // a spent beat returns as a fresh credit once consumed by the core
    wire logic [`TCS_CRED_W-1:0] pend_d = pend_q - (grant_w ? 4'h1 : 4'h0) + (beat_w ? 4'h1 : 4'h0);

    // ****************************************
    // link state machine
    // ****************************************
    tcs_link_t link_d;
    always_comb begin
        link_d = link_q;
        case (link_q)
            TCS_IDLE:  if (i_active_req) link_d = TCS_GRANT;
            TCS_GRANT: if (!i_active_req) link_d = TCS_IDLE;
                       else if (pend_d == 4'h0) link_d = TCS_RUN;
            TCS_RUN:   if (!i_active_req) link_d = TCS_IDLE;
            default:   link_d = TCS_IDLE;
        endcase
    end

    // ****************************************
    // sequential state
    // ****************************************
    // link and credits; leaving active drops held credits, returns refill
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            link_q   <= TCS_IDLE;
            credit_q <= 4'h0;
            pend_q   <= `TCS_CREDITS;
        end else begin
            link_q   <= link_d;
            credit_q <= (link_d == TCS_IDLE) ? 4'h0 : credit_d;
            pend_q   <= (link_d == TCS_IDLE) ? `TCS_CREDITS : pend_d;     // [RL14]
        end
    end

    // handshake outputs
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_active_ack <= 1'b0;
            o_credit_gnt <= 1'b0;
        end else begin
            o_active_ack <= (link_d != TCS_IDLE);
            o_credit_gnt <= grant_w;                                      // [RL14]
        end
    end

    // packet tracking across beats
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            in_pkt_q    <= 1'b0;
            taint_q     <= 1'b0;
            pkt_count_q <= 16'h0;
        end else if (beat_w) begin
            in_pkt_q    <= open_out;
            // an open packet stays doomed until its end beat
            taint_q     <= open_out && (doom_w || (n_sop == 3'h0 && taint_q)); // [RL11]
            pkt_count_q <= pkt_count_q + 16'(n_eop);
        end
    end

    // decoded beat outputs
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_end_valid   <= 4'h0;
            o_end_nullify <= 4'h0;
            o_end_dword   <= 16'h0;
            o_start_byte0 <= 8'h0;
            o_uncorr_err  <= 1'b0;
        end else begin
            o_end_valid   <= beat_w ? end_count_flags : 4'h0;             // [RL4]
            o_end_nullify <= beat_w ? null_w : 4'h0;                      // [RL10]
            o_end_dword   <= beat_w ? end_dwords : 16'h0;                 // [RL6] [RL7] [RL8]
            o_start_byte0 <= beat_w && start_count_flags[0] ?
                             8'(first_start_slot) * 8'(`TCS_SLOT_BYTES) : 8'h0; // [RL1]
            o_uncorr_err  <= ev_w[`TCS_EV_PARITY];                        // [RL13]
        end
    end

    // registers and interrupt
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            {drop_code_q, par_en_q} <= `TCS_CTRL_RESET;
            stat_q      <= 4'h0;
            mask_q      <= 4'h0;
            rdata_q     <= 32'h0;
            o_irq       <= 1'b0;
        end else begin
            if (wr_ctrl) {drop_code_q, par_en_q} <= i_reg_wdata[1:0];
            if (wr_mask) mask_q <= i_reg_wdata[`TCS_EV_W-1:0];
            stat_q  <= stat_d;
            rdata_q <= i_reg_rd ? rd_mux : 32'h0;
            o_irq   <= |(stat_d & mask_q);
        end
    end
    assign o_reg_rdata = rdata_q;
endmodule : tcs_tx_sideband

/* testbench/tcs_tx_sideband_monitor.sv */
// port-level checker for the transmit sideband decoder
`timescale 1ns/1ps
module tcs_tx_sideband_monitor
    import tcs_pkg::*;
(
    input wire logic        i_clk,         // user clock
    input wire logic        i_reset_n,     // sync reset
    input wire logic [99:0] i_tx_user,     // sideband word
    input wire logic        i_tx_valid,    // beat valid
    input wire logic        i_active_req,  // activation request
    input wire logic        o_active_ack,  // link active
    input wire logic        o_credit_gnt,  // credit pulse
    input wire logic [3:0]  o_end_valid,   // ending lanes
    input wire logic [3:0]  o_end_nullify, // nullified lanes
    input wire logic [15:0] o_end_dword,   // end dword indices
    input wire logic [7:0]  o_start_byte0, // first start byte
    input wire logic        o_uncorr_err   // parity error pulse
);
    // ****************************************
    // beat acceptance and properties
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // a beat only counts while the link is active
    wire logic beat_w = i_tx_valid && o_active_ack;
    a_end_flags: assert property (beat_w |=> o_end_valid == $past(i_tx_user[15:12]))
        else $error("end lanes do not follow end flags");
    a_end_quiet: assert property (!beat_w |=> o_end_valid == 4'h0)
        else $error("end lanes without accepted beat");
    a_dword_first: assert property (beat_w && i_tx_user[12] |=> o_end_dword[3:0] == $past(i_tx_user[23:20]))
        else $error("first end dword wrong");
    a_dword_second: assert property (beat_w && i_tx_user[13] |=> o_end_dword[7:4] == $past(i_tx_user[27:24]))
        else $error("second end dword wrong");
    a_dword_third: assert property (beat_w && i_tx_user[14] |=> o_end_dword[11:8] == $past(i_tx_user[31:28]))
        else $error("third end dword wrong");
    a_dword_fourth: assert property (beat_w && i_tx_user[15] |=> o_end_dword[15:12] == $past(i_tx_user[35:32]))
        else $error("fourth end dword wrong");
    a_start_byte: assert property (beat_w && i_tx_user[0] |=> o_start_byte0 == {2'h0, $past(i_tx_user[5:4]), 4'h0})
        else $error("first start byte wrong");
    // abort bits are per lane: an ending lane with its abort bit set must drop
    a_abort_null: assert property (beat_w |=> !(o_end_valid & $past(i_tx_user[19:16]) & ~o_end_nullify))
        else $error("aborted ending lane not nullified");
    a_null_ends: assert property ((o_end_nullify & ~o_end_valid) == 4'h0)
        else $error("nullify on a lane that does not end");
    a_ack_follows: assert property ($rose(i_active_req) |=> o_active_ack)
        else $error("activation not acknowledged");
    // grants start the cycle after the acknowledge, as the state register leads
    a_grant_burst: assert property ($rose(o_active_ack) |=> o_credit_gnt [*8])
        else $error("initial credit burst short");
    a_err_beat: assert property (o_uncorr_err |-> $past(beat_w))
        else $error("parity error without beat");
endmodule : tcs_tx_sideband_monitor

bind tcs_tx_sideband tcs_tx_sideband_monitor mon_u (
    .i_clk, .i_reset_n, .i_tx_user, .i_tx_valid, .i_active_req, .o_active_ack,
    .o_credit_gnt, .o_end_valid, .o_end_nullify, .o_end_dword, .o_start_byte0, .o_uncorr_err
);

/* testbench/tcs_sender_model.sv */
// application-side sender model feeding beats under credit control
`timescale 1ns/1ps
module tcs_sender_model
    import tcs_pkg::*;
(
    input  wire logic        i_clk,     // user clock
    input  wire logic        i_reset_n, // sync reset
    input  wire logic        i_go,      // start one packet
    input  wire logic [3:0]  i_len,     // beats in packet
    input  wire logic [2:0]  i_cnt,     // packets in the beat
    input  wire logic [3:0]  i_abt_at,  // abort beat, f for none
    input  wire logic        i_bad_par, // corrupt one parity bit
    input  wire logic [15:0] i_dw,      // end dwords and data seed
    input  wire logic        i_gnt,     // credit pulse
    input  wire logic        i_ack,     // link active
    output logic [511:0]     o_data,    // beat data
    output logic [99:0]      o_user,    // sideband word
    output logic             o_valid,   // beat valid
    output logic             o_busy     // packet pending
);
    // ****************************************
    // credit-paced beat sequencer
    // ****************************************
    logic [3:0]   cred_q, beat_q, len_q, abt_q; // state
    logic [2:0]   cnt_q;                        // packets per beat
    logic [15:0]  dw_q;                         // dword seed
    logic         bad_q;                        // parity fault
    logic [99:0]  u_w;                          // sideband while valid
    wire logic         take_w = o_valid && i_ack;
    wire logic         last_w = beat_q == len_q - 4'h1;
    wire logic [3:0]   cred_d = cred_q + {3'h0, i_gnt} - {3'h0, take_w};
    wire logic [3:0]   th_w   = 4'((5'h1 << cnt_q) - 5'h1);
    wire logic [511:0] d_w    = {32{dw_q ^ {12'h0, beat_q}}};
    // valid is raised only while a credit is held, never ahead of grants
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            {cred_q, beat_q, o_valid, o_busy} <= '0;
        end else begin
            cred_q <= cred_d;
            if (i_go) begin
                {len_q, cnt_q, abt_q, dw_q, bad_q, beat_q} <= {i_len, i_cnt, i_abt_at, i_dw, i_bad_par, 4'h0};
                o_busy <= 1'b1;
            end else if (take_w) begin
                beat_q <= beat_q + 4'h1;
                o_busy <= !last_w;
            end
            o_valid <= (i_go || (o_busy && !(take_w && last_w))) && cred_d != 4'h0 && i_ack;
        end
    end
    // sideband fields; a released bus shows the inverse, not the old word
    always_comb begin
        u_w = '0;
        u_w[3:0] = (beat_q == 4'h0) ? th_w : 4'h0;
        u_w[11:4] = {2'h3, 2'h2, 2'h1, (cnt_q == 3'h1) ? dw_q[1:0] : 2'h0};
        u_w[15:12] = last_w ? th_w : 4'h0;
        u_w[19:16] = {3'h0, beat_q >= abt_q};
        u_w[35:20] = dw_q;
        for (int i = 0; i < 64; i++) u_w[36+i] = ~^d_w[8*i +: 8];
        u_w[36] = u_w[36] ^ bad_q;
        o_user = o_valid ? u_w : ~u_w;
        o_data = o_valid ? d_w : ~d_w;
    end
endmodule : tcs_sender_model

/* testbench/tcs_tx_sideband_tb.sv */
// self-checking bench for the transmit sideband decoder
`timescale 1ns/1ps
module tcs_tx_sideband_tb
    import tcs_pkg::*;
;
    // ****************************************
    // signals, clock, instances, tallies
    // ****************************************
    logic         clk, rst_n, go, bad, req, wr, rd, valid, busy, gnt, ack, uerr, irq;
    logic [3:0]   len, abt, addr, endv, nul;
    logic [2:0]   cnt;
    logic [15:0]  dw;
    logic [31:0]  wdata, rdata;
    logic [511:0] data;
    logic [99:0]  user;
    int           n_fail = 0, n_checks = 0, ends = 0, nuls = 0, gnts = 0, errs = 0, x_end = 0, x_nul = 0;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    tcs_tx_sideband dut_u (.i_clk(clk), .i_reset_n(rst_n), .i_tx_data(data), .i_tx_user(user), .i_tx_valid(valid),
        .i_active_req(req), .i_credit_rtn(1'b0), .o_active_ack(ack), .o_credit_gnt(gnt), .o_end_valid(endv),
        .o_end_nullify(nul), .o_end_dword(), .o_start_byte0(), .o_uncorr_err(uerr), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_irq(irq));
    tcs_sender_model snd_u (.i_clk(clk), .i_reset_n(rst_n), .i_go(go), .i_len(len), .i_cnt(cnt), .i_abt_at(abt),
        .i_bad_par(bad), .i_dw(dw), .i_gnt(gnt), .i_ack(ack), .o_data(data), .o_user(user), .o_valid(valid),
        .o_busy(busy));
    // pulse outputs stand one cycle, so they are tallied every edge
    always @(posedge clk) begin
        ends += $countones(endv);
        nuls += $countones(nul);
        gnts += int'(gnt);
        errs += int'(uerr);
    end
    // ****************************************
    // tasks and expectation functions
    // ****************************************
    // the model raises abort bit 0 only, so an abort drops lane 0 alone
    function automatic int nul_of(input logic [3:0] ab, input logic bp, input logic [2:0] c);
        return bp ? int'(c) : (ab != 4'hf) ? 1 : 0;
    endfunction : nul_of
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] act);
        n_checks++;
        if (act !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, exp, act);
        end
    endtask : chk
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : reg_wr
    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp, input string nm);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, exp, rdata & m);
        @(posedge clk);
    endtask : reg_rd
    task automatic send(input logic [3:0] l, input logic [2:0] c, input logic [3:0] ab, input logic bp);
        int k = 0;
        {len, cnt, abt, bad, go} <= {l, c, ab, bp, 1'b1};
        dw <= 16'($urandom);
        x_end += int'(c);
        x_nul += nul_of(ab, bp, c);
        @(posedge clk);
        go <= 1'b0;
        do @(posedge clk); while (busy && k++ < 200);
        chk("send done", 32'h0, {31'h0, busy});
        repeat (2) @(posedge clk);
    endtask : send
    task automatic final_report;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        #300us;
        n_fail++;
        final_report();
    end
    initial begin
        {go, bad, req, wr, rd, len, abt, addr, cnt, dw, wdata} = '0;
        rst_n = 1'b0;
        void'($urandom(32'hfad2));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        reg_rd(4'h0, '1, 32'h0, "ctrl");
        reg_rd(4'h1, '1, 32'h0, "status");
        reg_rd(4'hf, '1, 32'h0, "unmapped");
        req <= 1'b1;
        repeat (12) @(posedge clk);
        chk("grants", 32'd8, 32'(gnts));
        reg_wr(4'h0, 32'h3);
        reg_rd(4'h0, '1, 32'h3, "ctrl set");
        reg_wr(4'h2, 32'h3);
        for (int c = 4; c >= 1; c--) send(4'h1, 3'(c), 4'hf, 1'b0);
        for (int i = 0; i < 24; i++) begin
            automatic logic [2:0] rc = 3'($urandom_range(4, 1));
            send((rc == 3'h1) ? 4'($urandom_range(4, 1)) : 4'h1, rc, 4'hf, 1'b0);
        end
        chk("ends", 32'(x_end), 32'(ends));
        chk("clean nullify", 32'h0, 32'(nuls));
        reg_rd(4'h4, '1, 32'(x_end), "ended count");
        chk("irq idle", 32'h0, {31'h0, irq});
        send(4'h3, 3'h1, 4'h1, 1'b0);
        send(4'h1, 3'h2, 4'h0, 1'b0);
        chk("abort nullify", 32'(x_nul), 32'(nuls));
        reg_rd(4'h1, 32'h3, 32'h1, "abort status");
        chk("irq raised", 32'h1, {31'h0, irq});
        reg_wr(4'h2, 32'h0);
        @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        reg_wr(4'h2, 32'h3);
        reg_wr(4'h1, 32'h1);
        @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        send(4'h2, 3'h1, 4'hf, 1'b1);
        chk("parity errors", 32'h1, 32'(errs > 0));
        chk("parity nullify", 32'(x_nul), 32'(nuls));
        reg_rd(4'h1, 32'h3, 32'h2, "parity status");
        final_report();
    end
endmodule : tcs_tx_sideband_tb
